// ### design/gpio_pkg.sv
// Purpose: constants shared by the parallel i/o port control block
// Assumes: apb slave with 32-bit data, 25 MHz bus clock, three ports of 16 pins total
// Notes:   pin counts per port are a fixed split: port a 8, port b 4, port c 4
//
// What this block does
// - Three parallel ports together give sixteen individually controlled pins.
// - An enabled shared peripheral takes a pin away from the general-purpose logic.
// - After reset every shared function is off and every pin is an input.
// - After reset slew limiting, high drive and pull-up bits are all clear.
// - With no shared function the direction bit enables the output buffer and picks the read source.
// - The input buffer stays on except for analog pins and output-only pins.
// - An enabled shared digital function drives the output buffer enable instead of the direction bit.
// - The direction bit still picks the read source while a digital function owns the pin.
// - An enabled analog function turns off both input and output buffers.
// - A data read gives zero for an input pin whose input buffer is off.
// - When digital and analog functions are both enabled the analog one wins.
package gpio_pkg;

	// ****************************************
	// geometry
	// ****************************************
	localparam int PIN_COUNT  = 16;
	localparam int PORT_COUNT = 3;
	localparam int PORTA_W    = 8;
	localparam int PORTB_W    = 4;
	localparam int PORTC_W    = 4;
	localparam int PORTA_LSB  = 0;
	localparam int PORTB_LSB  = 8;
	localparam int PORTC_LSB  = 12;

	// ****************************************
	// register byte offsets (three per port)
	// ****************************************
	localparam logic [7:0] OFS_A_DATA = 8'h00;
	localparam logic [7:0] OFS_A_DIR  = 8'h04;
	localparam logic [7:0] OFS_A_PAD  = 8'h08;
	localparam logic [7:0] OFS_B_DATA = 8'h10;
	localparam logic [7:0] OFS_B_DIR  = 8'h14;
	localparam logic [7:0] OFS_B_PAD  = 8'h18;
	localparam logic [7:0] OFS_C_DATA = 8'h20;
	localparam logic [7:0] OFS_C_DIR  = 8'h24;
	localparam logic [7:0] OFS_C_PAD  = 8'h28;
	localparam logic [7:0] OFS_SHARE  = 8'h30;
	localparam logic [7:0] OFS_ANALOG = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;

	// pad control register field positions (per pin byte lanes)
	localparam int PAD_SLEW_LSB  = 0;
	localparam int PAD_DRIVE_LSB = 8;
	localparam int PAD_PULL_LSB  = 16;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [15:0] RST_DATA   = 16'h0000;
	localparam logic [15:0] RST_DIR    = 16'h0000;
	localparam logic [15:0] RST_PAD    = 16'h0000;
	localparam logic [15:0] RST_SHARE  = 16'h0000;
	localparam logic [15:0] RST_ANALOG = 16'h0000;

	// pins with no input buffer; none by default
	localparam logic [15:0] OUT_ONLY_MASK = 16'h0000;

	// apb slave states
	typedef enum logic [1:0] {
		APB_IDLE   = 2'b01,
		APB_ACCESS = 2'b10
	} apb_state_t;

	// port number of a byte address, 3 for non-port registers
	function automatic logic [1:0] portOf(input logic [7:0] addr);
		portOf = addr[5:4];
	endfunction : portOf

endpackage : gpio_pkg

// ### design/pin_sync.sv
// Purpose: two-stage synchroniser for the sixteen pin input levels
// Assumes: pin levels are asynchronous to mclk
// Notes:   first stage is read only by the second stage
`timescale 1ns/100ps
module pin_sync
	import gpio_pkg::*;
(
	input  wire logic                 mclk,    // bus clock
	input  wire logic                 rst_n,   // async reset, low
	input  wire logic [PIN_COUNT-1:0] asyncIn, // raw pin levels
	output logic      [PIN_COUNT-1:0] syncOut  // synchronised levels
);

	logic [PIN_COUNT-1:0] stage1_ff;
	logic [PIN_COUNT-1:0] stage2_ff;

	// two flops, metastability settles in the first
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stage1_ff <= 16'h0000;
			stage2_ff <= 16'h0000;
		end else begin
			stage1_ff <= asyncIn;
			stage2_ff <= stage1_ff;
		end
	end

	assign syncOut = stage2_ff;

endmodule : pin_sync

// ### design/pin_mux.sv
// Purpose: per-pin buffer ownership and read-source selection
// Assumes: all inputs on mclk domain, pin level already synchronised
// Notes:   purely combinational; analog beats digital beats direction bit
`timescale 1ns/100ps
module pin_mux
	import gpio_pkg::*;
(
	input  wire logic [PIN_COUNT-1:0] dirBits,     // direction bits, 1 = output
	input  wire logic [PIN_COUNT-1:0] latchBits,   // output latch
	input  wire logic [PIN_COUNT-1:0] shareEn,     // shared digital enables
	input  wire logic [PIN_COUNT-1:0] shareOe,     // shared function output enable
	input  wire logic [PIN_COUNT-1:0] shareOut,    // shared function output data
	input  wire logic [PIN_COUNT-1:0] analogEn,    // analog function enables
	input  wire logic [PIN_COUNT-1:0] pinLevel,    // synchronised pin level
	output logic      [PIN_COUNT-1:0] outEnable,   // output buffer enable
	output logic      [PIN_COUNT-1:0] outValue,    // value at output buffer
	output logic      [PIN_COUNT-1:0] inBufEn,     // input buffer enable
	output logic      [PIN_COUNT-1:0] readValue    // port data read value
);

	logic [PIN_COUNT-1:0] digOwn;
	logic [PIN_COUNT-1:0] gatedIn;

	// digital function owns the pin only when analog is off
	assign digOwn    = shareEn & ~analogEn;
	// buffer enable: analog kills it, digital owns it, else direction
	assign outEnable = ~analogEn & ((digOwn & shareOe) | (~shareEn & dirBits));
	assign outValue  = (digOwn & shareOut) | (~shareEn & latchBits);
	// input buffer off for analog and output-only pins
	assign inBufEn   = ~analogEn & ~OUT_ONLY_MASK;
	assign gatedIn   = pinLevel & inBufEn;
	// direction bit picks the read source even under digital ownership
	assign readValue = (dirBits & latchBits) | (~dirBits & gatedIn);

endmodule : pin_mux

// ### design/parallel_io_port_control.sv
// Purpose: apb-mapped control of three parallel ports, sixteen pins
// Assumes: apb master on mclk; shared peripherals drive enables on mclk
// Notes:   pad control bits are stored and exported, pad cells act on them
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
module parallel_io_port_control
	import gpio_pkg::*;
(
	input  wire logic                 mclk,          // bus clock, 25 MHz
	input  wire logic                 rst_n,         // async reset, low
	input  wire logic                 psel,          // apb select
	input  wire logic                 penable,       // apb enable
	input  wire logic                 pwrite,        // apb write
	input  wire logic [7:0]           paddr,         // apb byte address
	input  wire logic [31:0]          pwdata,        // apb write data
	input  wire logic [3:0]           pstrb,         // apb byte strobes
	output logic      [31:0]          prdata,        // apb read data
	output logic                      pready,        // apb ready
	output logic                      pslverr,       // apb error
	input  wire logic [PIN_COUNT-1:0] pinIn,         // pad input levels
	output logic      [PIN_COUNT-1:0] pinOut,        // pad output data
	output logic      [PIN_COUNT-1:0] pinOe,         // pad output enable
	output logic      [PIN_COUNT-1:0] pinInEn,       // pad input buffer enable
	output logic      [PIN_COUNT-1:0] slewLimitEn,   // slew limit per pin
	output logic      [PIN_COUNT-1:0] highDriveSel,  // high drive per pin
	output logic      [PIN_COUNT-1:0] pullupEn,      // pull-up per pin
	output logic      [PIN_COUNT-1:0] shareEnable,   // shared digital enables
	output logic      [PIN_COUNT-1:0] analogEnable,  // analog enables
	input  wire logic [PIN_COUNT-1:0] periphOe,      // shared function oe
	input  wire logic [PIN_COUNT-1:0] periphOut      // shared function data
);

	// ****************************************
	// storage
	// ****************************************
	logic [PIN_COUNT-1:0] latch_ff;
	logic [PIN_COUNT-1:0] dir_ff;
	logic [PIN_COUNT-1:0] slew_ff;
	logic [PIN_COUNT-1:0] drive_ff;
	logic [PIN_COUNT-1:0] pull_ff;
	logic [PIN_COUNT-1:0] share_ff;
	logic [PIN_COUNT-1:0] analog_ff;
	logic [31:0]          rdata_ff;
	apb_state_t           state_ff;
	apb_state_t           nxt_state;

	logic [PIN_COUNT-1:0] pinSync;
	logic [PIN_COUNT-1:0] readValue;
	logic [PIN_COUNT-1:0] outEnable;
	logic [PIN_COUNT-1:0] outValue;
	logic [PIN_COUNT-1:0] inBufEn;

	// ****************************************
	// input sync and pin muxing
	// ****************************************
	pin_sync u_sync (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.asyncIn (pinIn),
		.syncOut (pinSync)
	);

	pin_mux u_mux (
		.dirBits   (dir_ff),
		.latchBits (latch_ff),
		.shareEn   (share_ff),
		.shareOe   (periphOe),
		.shareOut  (periphOut),
		.analogEn  (analog_ff),
		.pinLevel  (pinSync),
		.outEnable (outEnable),
		.outValue  (outValue),
		.inBufEn   (inBufEn),
		.readValue (readValue)
	);

	// ****************************************
	// apb decode
	// ****************************************
	// a zero-wait-state slave: setup, then access with pready high
	wire        setupPh  = psel & ~penable;
	wire        accessPh = psel & penable & (state_ff == APB_ACCESS);
	wire [1:0]  portSel  = portOf(paddr);
	wire [3:0]  regSel   = paddr[3:0];
	wire        isData   = (portSel != 2'd3) && (regSel == 4'h0);
	wire        isDir    = (portSel != 2'd3) && (regSel == 4'h4);
	wire        isPad    = (portSel != 2'd3) && (regSel == 4'h8);
	wire        isShare  = (paddr == OFS_SHARE);
	wire        isAnalog = (paddr == OFS_ANALOG);
	wire        isStatus = (paddr == OFS_STATUS);
	wire        mapped   = isData | isDir | isPad | isShare | isAnalog | isStatus;
	wire        wrStrobe = accessPh & pwrite & mapped;

	// pin positions of the addressed port
	wire [PIN_COUNT-1:0] portMask;
	wire [4:0]           portLsb;
	assign portMask = (portSel == 2'd0) ? 16'h00FF :
	                  (portSel == 2'd1) ? 16'h0F00 :
	                  (portSel == 2'd2) ? 16'hF000 : 16'h0000;
	assign portLsb  = (portSel == 2'd0) ? 5'(PORTA_LSB) :
	                  (portSel == 2'd1) ? 5'(PORTB_LSB) : 5'(PORTC_LSB);

	// byte-lane strobes, only lane 0 matters for port bits
	wire [PIN_COUNT-1:0] laneMask = pstrb[0] ? portMask : 16'h0000;
	wire [PIN_COUNT-1:0] wrPort   = 16'(pwdata[7:0]) << portLsb;

	// merged write value for a port-wide field
	function automatic logic [PIN_COUNT-1:0] merge(
		input logic [PIN_COUNT-1:0] old,
		input logic [PIN_COUNT-1:0] val,
		input logic [PIN_COUNT-1:0] mask);
		merge = (old & ~mask) | (val & mask);
	endfunction : merge

	wire [PIN_COUNT-1:0] slewWr  = 16'(pwdata[PAD_SLEW_LSB  +: 8]) << portLsb;
	wire [PIN_COUNT-1:0] driveWr = 16'(pwdata[PAD_DRIVE_LSB +: 8]) << portLsb;
	wire [PIN_COUNT-1:0] pullWr  = 16'(pwdata[PAD_PULL_LSB  +: 8]) << portLsb;
	wire [PIN_COUNT-1:0] padM1   = pstrb[1] ? portMask : 16'h0000;
	wire [PIN_COUNT-1:0] padM2   = pstrb[2] ? portMask : 16'h0000;
	wire [15:0]          wide16  = {pstrb[1] ? pwdata[15:8] : 8'h00,
	                                pstrb[0] ? pwdata[7:0]  : 8'h00};
	wire [15:0]          wideM   = {pstrb[1] ? 8'hFF : 8'h00, pstrb[0] ? 8'hFF : 8'h00};

	// read mux, port fields right-justified
	wire [PIN_COUNT-1:0] rdShift = (readValue & portMask) >> portLsb;
	wire [PIN_COUNT-1:0] dirSh   = (dir_ff    & portMask) >> portLsb;
	wire [PIN_COUNT-1:0] slewSh  = (slew_ff   & portMask) >> portLsb;
	wire [PIN_COUNT-1:0] drvSh   = (drive_ff  & portMask) >> portLsb;
	wire [PIN_COUNT-1:0] pullSh  = (pull_ff   & portMask) >> portLsb;
	wire [31:0] rdMux;
	assign rdMux = isData   ? {24'h000000, rdShift[7:0]} :
	               isDir    ? {24'h000000, dirSh[7:0]} :
	               isPad    ? {8'h00, pullSh[7:0], drvSh[7:0], slewSh[7:0]} :
	               isShare  ? {16'h0000, share_ff} :
	               isAnalog ? {16'h0000, analog_ff} :
	               isStatus ? {16'h0000, outEnable} : 32'h00000000;

	// ****************************************
	// apb state machine
	// ****************************************
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			APB_IDLE:   if (setupPh) nxt_state = APB_ACCESS;
			APB_ACCESS: nxt_state = APB_IDLE;
			default:    nxt_state = APB_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= APB_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// read data captured in setup so it stands through access
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 32'h00000000;
		end else if (setupPh && !pwrite) begin
			rdata_ff <= rdMux;
		end
	end

	assign pready  = accessPh;
	assign pslverr = accessPh & ~mapped;
	assign prdata  = rdata_ff;

	// ****************************************
	// register writes
	// ****************************************
	// latch written regardless of direction, so load-then-enable is glitch free
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			latch_ff <= RST_DATA;
		end else if (wrStrobe && isData) begin
			latch_ff <= merge(latch_ff, wrPort, laneMask);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dir_ff <= RST_DIR;
		end else if (wrStrobe && isDir) begin
			dir_ff <= merge(dir_ff, wrPort, laneMask);
		end
	end

	// pad controls, cleared on reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			slew_ff  <= RST_PAD;
			drive_ff <= RST_PAD;
			pull_ff  <= RST_PAD;
		end else if (wrStrobe && isPad) begin
			slew_ff  <= merge(slew_ff, slewWr, laneMask);
			drive_ff <= merge(drive_ff, driveWr, padM1);
			pull_ff  <= merge(pull_ff, pullWr, padM2);
		end
	end

	// shared-function enables, all off after reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			share_ff  <= RST_SHARE;
			analog_ff <= RST_ANALOG;
		end else begin
			if (wrStrobe && isShare) begin
				share_ff <= merge(share_ff, wide16, wideM);
			end
			if (wrStrobe && isAnalog) begin
				analog_ff <= merge(analog_ff, wide16, wideM);
			end
		end
	end

	// ****************************************
	// pin side outputs
	// ****************************************
	// pull-up is meaningless on driven or analog pins, pullupEn masks it here
	assign pinOut       = outValue;
	assign pinOe        = outEnable;
	assign pinInEn      = inBufEn;
	assign slewLimitEn  = slew_ff;
	assign highDriveSel = drive_ff;
	assign pullupEn     = pull_ff & ~outEnable & ~analog_ff;
	assign shareEnable  = share_ff;
	assign analogEnable = analog_ff;

endmodule : parallel_io_port_control

// ### tb/parallel_io_port_control_monitor.sv
// Purpose: assertions on pad ownership and apb answers of the port block
// Assumes: single clock domain, async active-low reset
// Notes:   sees only the top ports, so status reads are judged against the pad output enables
`timescale 1ns/100ps
module parallel_io_port_control_monitor
	import gpio_pkg::*;
(
	input wire logic                 mclk,         // bus clock
	input wire logic                 rst_n,        // reset, low
	input wire logic                 psel,         // apb select
	input wire logic                 penable,      // apb enable
	input wire logic                 pwrite,       // apb write
	input wire logic [7:0]           paddr,        // apb address
	input wire logic [31:0]          pwdata,       // apb write data
	input wire logic [3:0]           pstrb,        // apb strobes
	input wire logic [31:0]          prdata,       // apb read data
	input wire logic                 pready,       // apb ready
	input wire logic                 pslverr,      // apb error
	input wire logic [PIN_COUNT-1:0] pinIn,        // pad levels
	input wire logic [PIN_COUNT-1:0] pinOut,       // pad data
	input wire logic [PIN_COUNT-1:0] pinOe,        // pad enable
	input wire logic [PIN_COUNT-1:0] pinInEn,      // input buffer
	input wire logic [PIN_COUNT-1:0] slewLimitEn,  // slew limit
	input wire logic [PIN_COUNT-1:0] highDriveSel, // high drive
	input wire logic [PIN_COUNT-1:0] pullupEn,     // pull-up
	input wire logic [PIN_COUNT-1:0] shareEnable,  // digital share
	input wire logic [PIN_COUNT-1:0] analogEnable, // analog share
	input wire logic [PIN_COUNT-1:0] periphOe,     // peripheral oe
	input wire logic [PIN_COUNT-1:0] periphOut     // peripheral data
);
	// ****************************************
	// helpers
	// ****************************************
	// addresses that answer without error
	wire logic mapped;
	wire logic [PIN_COUNT-1:0] digOwn;
	assign mapped = paddr inside {OFS_A_DATA, OFS_A_DIR, OFS_A_PAD, OFS_B_DATA, OFS_B_DIR,
		OFS_B_PAD, OFS_C_DATA, OFS_C_DIR, OFS_C_PAD, OFS_SHARE, OFS_ANALOG, OFS_STATUS};
	// pins a digital peripheral owns outright
	assign digOwn = shareEnable & ~analogEnable;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// ****************************************
	// assertions
	// ****************************************
	analog_oe_a: assert property ((pinOe & analogEnable) == 16'h0000)
		else $error("output enabled on analog pin");
	inbuf_en_a: assert property (pinInEn == ~analogEnable)
		else $error("input buffer enable wrong");
	share_oe_a: assert property (((pinOe ^ periphOe) & digOwn) == 16'h0000)
		else $error("shared pin oe not from peripheral");
	share_out_a: assert property (((pinOut ^ periphOut) & digOwn & pinOe) == 16'h0000)
		else $error("shared pin data not from peripheral");
	reset_clear_a: assert property ($rose(rst_n) |-> ((pinOe | shareEnable | analogEnable
		| slewLimitEn | highDriveSel | pullupEn) == 16'h0000) && pinInEn == 16'hFFFF)
		else $error("pins not cleared by reset");
	status_oe_a: assert property (pready && !pwrite && paddr == OFS_STATUS
		|-> prdata[15:0] == $past(pinOe)) else $error("status read differs from pad enable");
	pull_gate_a: assert property ((pullupEn & (pinOe | analogEnable)) == 16'h0000)
		else $error("pull-up on driven or analog pin");
	ready_next_a: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	ready_only_a: assert property (!(psel && penable) |-> !pready && !pslverr)
		else $error("ready outside access");
	err_map_a: assert property (pready |-> pslverr == !mapped)
		else $error("error flag disagrees with address map");
endmodule : parallel_io_port_control_monitor

bind parallel_io_port_control parallel_io_port_control_monitor parallel_io_port_control_monitor_i (.*);

// ### tb/pin_partner.sv
// Purpose: board and shared peripheral seen by the pads
// Assumes: board drivers always hold a level, so no pad floats
// Notes:   peripheral outputs are static plans set by the bench
`timescale 1ns/100ps
module pin_partner
	import gpio_pkg::*;
(
	input  wire logic [PIN_COUNT-1:0] pinOut,    // block pad data
	input  wire logic [PIN_COUNT-1:0] pinOe,     // block pad enable
	input  wire logic [PIN_COUNT-1:0] extLevel,  // board level
	input  wire logic [PIN_COUNT-1:0] perOeCfg,  // peripheral oe plan
	input  wire logic [PIN_COUNT-1:0] perOutCfg, // peripheral data plan
	output logic      [PIN_COUNT-1:0] pinIn,     // level at pads
	output logic      [PIN_COUNT-1:0] periphOe,  // peripheral oe
	output logic      [PIN_COUNT-1:0] periphOut  // peripheral data
);
	// ****************************************
	// wire levels
	// ****************************************
	// board backs off where the block drives, avoiding contention
	assign pinIn     = (pinOe & pinOut) | (~pinOe & extLevel);
	assign periphOe  = perOeCfg;
	assign periphOut = perOutCfg;
endmodule : pin_partner

// ### tb/parallel_io_port_control_test.sv
// Purpose: apb sequence test of pad ownership, read source and reset
// Assumes: apb slave answers in its own time, two-flop pin synchroniser
// Notes:   expectations come from a small shadow of every written register
`timescale 1ns/100ps
module parallel_io_port_control_test
	import gpio_pkg::*;
;
	logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic [15:0] pinIn, pinOut, pinOe, pinInEn, slewLimitEn, highDriveSel, pullupEn;
	logic [15:0] shareEnable, analogEnable, periphOe, periphOut, extLevel, perOeCfg, perOutCfg;
	logic [15:0] latchE, dirE, shareE, anaE, slewE, drvE, pullE;
	int          errorCnt, checked;

	parallel_io_port_control parallel_io_port_control_i (.*);
	pin_partner pin_partner_i (.*);

	// ****************************************
	// clock and watchdog
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// whole run is under two hundred cycles
	initial begin
		repeat (5000) @(posedge mclk);
		errorCnt++;
		finish_test();
	end

	// ****************************************
	// tasks
	// ****************************************
	task finish_test();
		if (errorCnt == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task chkWord(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errorCnt++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask : chkWord
	task chkPins(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errorCnt++;
			$display("ERROR %0t pins %h expected %h", $time, got, exp);
		end
	endtask : chkPins
	// psel stays up so calls run back to back; idle releases it
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// only the watchdog may end this wait
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
	endtask : xfer
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, a, d, r, e);
		chkWord({31'h0, e}, 32'h0);
	endtask : wr
	task idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge mclk);
	endtask : idle
	// settle the synchroniser, then compare pads and the data, A and C dir, A pad and status readbacks
	task checkAll();
		logic [31:0] r;
		logic        e;
		logic [15:0] oe, out, lvl, rd;
		idle(4);
		oe = ~anaE & ((shareE & perOeCfg) | (~shareE & dirE));
		out = (shareE & perOutCfg) | (~shareE & latchE);
		lvl = (oe & out) | (~oe & extLevel);
		rd = (dirE & latchE) | (~dirE & lvl & ~anaE);
		chkPins(pinOe, oe);
		chkPins(pinOut & oe, out & oe);
		chkPins(pinInEn, ~anaE);
		chkPins(slewLimitEn, slewE);
		chkPins(highDriveSel, drvE);
		chkPins(pullupEn, pullE & ~oe & ~anaE);
		chkPins(shareEnable, shareE);
		chkPins(analogEnable, anaE);
		xfer(1'b0, OFS_A_DATA, 32'h0, r, e); chkWord(r, {24'h0, rd[7:0]});
		xfer(1'b0, OFS_B_DATA, 32'h0, r, e); chkWord(r, {28'h0, rd[11:8]});
		xfer(1'b0, OFS_C_DATA, 32'h0, r, e); chkWord(r, {28'h0, rd[15:12]});
		xfer(1'b0, OFS_A_DIR, 32'h0, r, e); chkWord(r, {24'h0, dirE[7:0]});
		xfer(1'b0, OFS_C_DIR, 32'h0, r, e); chkWord(r, {28'h0, dirE[15:12]});
		xfer(1'b0, OFS_A_PAD, 32'h0, r, e);
		chkWord(r, {8'h0, pullE[7:0], drvE[7:0], slewE[7:0]});
		xfer(1'b0, OFS_STATUS, 32'h0, r, e); chkWord(r, {16'h0, oe});
	endtask : checkAll
	task clearShadow();
		{latchE, dirE, shareE, anaE, slewE, drvE, pullE} = '0;
	endtask : clearShadow

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [31:0] r;
		logic        e;
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		extLevel = 16'h3C5A;
		perOeCfg = 16'h0F05;
		perOutCfg = 16'h5A5A;
		errorCnt = 0;
		checked = 0;
		clearShadow();
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		checkAll();
		xfer(1'b0, 8'h0C, 32'h0, r, e);
		chkWord({31'h0, e}, 32'h1);
		chkWord(r, 32'h0);
		// data first, direction after, so no stale value reaches a pad
		wr(OFS_A_DATA, 32'hA5);
		wr(OFS_B_DATA, 32'h9);
		wr(OFS_C_DATA, 32'h6);
		latchE = 16'h69A5;
		checkAll();
		wr(OFS_A_DIR, 32'hF0);
		wr(OFS_B_DIR, 32'h3);
		wr(OFS_C_DIR, 32'hC);
		dirE = 16'hC3F0;
		checkAll();
		wr(OFS_A_PAD, 32'h00C30F55);
		wr(OFS_B_PAD, 32'h000A0C06);
		wr(OFS_C_PAD, 32'h000F0509);
		{slewE, drvE, pullE} = {16'h9655, 16'h5C0F, 16'hFAC3};
		checkAll();
		wr(OFS_SHARE, 32'h0F0F);
		shareE = 16'h0F0F;
		checkAll();
		wr(OFS_ANALOG, 32'h0303);
		anaE = 16'h0303;
		checkAll();
		xfer(1'b1, 8'h3C, 32'hFFFF, r, e);
		chkWord({31'h0, e}, 32'h1);
		extLevel <= 16'hC3A5;
		checkAll();
		// second reset in mid-run with everything configured
		idle(1);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		clearShadow();
		@(posedge mclk);
		checkAll();
		idle(2);
		finish_test();
	end
endmodule : parallel_io_port_control_test
